/* flash_pins_pkg.sv */
package flash_pins_pkg;

  // Data widths
  localparam int BYTE_W     = 8;      // Bits per serial byte
  localparam int FIFO_DEPTH = 4;      // Words in the transmit buffer
  localparam int SYNC_W     = 3;      // Select, clock and input lane
  localparam int LANES      = 4;      // Data lanes on the pins
  localparam int SEC_PAGES  = 3;      // Security pages with own lock

  // Sync bus bit positions
  localparam int SYNC_CS  = 0;
  localparam int SYNC_SCK = 1;
  localparam int SYNC_SI  = 2;

  // Reset and idle values
  localparam logic [7:0] IDLE_FILL  = 8'hff;  // Sent when buffer runs dry
  localparam logic [3:0] OE_NONE    = 4'h0;   // All lanes released
  localparam logic [3:0] OE_X1      = 4'h2;   // Output lane only
  localparam logic [3:0] OE_X2      = 4'h3;   // Output lane plus turned input
  localparam logic [3:0] OE_X4      = 4'hf;   // All four lanes
  localparam logic [2:0] LOCK_RESET = 3'h0;   // Pages start writable
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_LAST   = 4'h7;   // Eighth input bit
  localparam logic [3:0] CNT_BYTE   = 4'h8;

  // Lane width for output data
  typedef enum logic [1:0] {
    LANE_X1,
    LANE_X2,
    LANE_X4
  } lane_mode_t;

  // Link power state
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_SELECTED,
    ST_BUSY
  } link_state_t;

endpackage : flash_pins_pkg

/* pin_sync.sv */
`timescale 1ns/1ps

// Two flip-flop synchroniser for pin inputs
module pin_sync #(
  parameter int             WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by second

  // Two stages, constants on reset
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta_q   <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

/* byte_fifo.sv */
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic [AW:0]      wr_q;         // Write pointer with wrap bit
  logic [AW:0]      rd_q;         // Read pointer with wrap bit
  logic [AW:0]      wr_d;         // Write pointer after this cycle
  logic [AW:0]      rd_d;         // Read pointer after this cycle
  logic             ready_q;      // Room for a word, registered
  wire              push;
  wire              pop;

  // Ready straight from a flop, so the fill side sees no pointer logic
  assign in_ready  = ready_q;
  assign wr_d      = wr_q + (AW+1)'(push);
  assign rd_d      = rd_q + (AW+1)'(pop);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  // Pointer update
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      ready_q <= 1'b1;
    end
    else
    begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      // Full when next pointers differ only in wrap bit
      ready_q <= !((wr_d[AW] != rd_d[AW]) && (wr_d[AW-1:0] == rd_d[AW-1:0]));
    end
  end

endmodule : byte_fifo

/* flash_pin_frontend.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Select low selects; high deselects to standby
// - Select fall starts, select rise ends operation
// - Self-timed cycle finishes before standby entry
// - Input lane captured on serial clock rise
// - Output data changes on serial clock fall
// - Dual/quad reads turn input lane output
// - Three security pages, each locked independently
// - Input lane ignored while deselected
// - Output lanes released while deselected
module flash_pin_frontend (
  // System clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Flash pins, sampled asynchronously
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si_in,
  output logic      [3:0] io_out_q,
  output logic      [3:0] io_oe_q,
  // Received bytes
  output logic      [7:0] rx_byte_q,
  output logic            rx_valid_q,
  // Transmit bytes into buffer
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // Read control from command logic
  input  wire logic       out_en,
  input  wire logic [1:0] lane_sel,
  // Self-timed cycle status
  input  wire logic       busy_in,
  // Security page locks
  input  wire logic [2:0] lock_req,
  output logic      [2:0] page_locked_q,
  // Link status
  output logic            selected_q,
  output logic            standby_q,
  output logic            frame_start_q,
  output logic            frame_end_q
);

  // Synchronised pins
  logic [flash_pins_pkg::SYNC_W-1:0] pins_s;     // Two-flop outputs
  logic                              cs_s;       // Select, high is idle
  logic                              sck_s;      // Serial clock level
  logic                              si_s;       // Input lane level
  logic                              cs_prev_q;  // Select one cycle ago
  logic                              sck_prev_q; // Clock one cycle ago

  // Edge and frame strobes
  wire rise_e;      // Serial clock rising edge
  wire fall_e;      // Serial clock falling edge
  wire sel_fall;    // Frame begins
  wire sel_rise;    // Frame ends

  // Link state
  flash_pins_pkg::link_state_t state_q;
  flash_pins_pkg::link_state_t state_d;

  // Receive path
  logic [7:0] rx_sh_q;   // Input shift register
  logic [3:0] rx_cnt_q;  // Bits received in byte

  // Transmit path
  logic [7:0] tx_sh_q;   // Output shift register
  logic [3:0] tx_cnt_q;  // Bits still to send
  wire        buf_valid; // Buffer holds a byte
  wire  [7:0] buf_data;  // Head of buffer
  wire        need_byte; // Falling edge needs a fresh byte
  wire        tx_fall;   // Falling edge while driving
  wire  [7:0] send_byte; // Byte whose top bits go out
  wire  [3:0] step;      // Bits per falling edge
  wire  [3:0] oe_d;      // Lane enables for this cycle
  wire  [3:0] out_d;     // Lane values on a falling edge

  flash_pins_pkg::lane_mode_t mode;  // Decoded lane width

  // Bits moved per edge for a lane width
  function automatic logic [3:0] lane_bits(flash_pins_pkg::lane_mode_t m);
    case (m)
      flash_pins_pkg::LANE_X2: lane_bits = 4'h2;
      flash_pins_pkg::LANE_X4: lane_bits = 4'h4;
      default:                 lane_bits = 4'h1;
    endcase
  endfunction : lane_bits

  // Lane enables for a lane width
  function automatic logic [3:0] lane_oe(flash_pins_pkg::lane_mode_t m);
    case (m)
      flash_pins_pkg::LANE_X2: lane_oe = flash_pins_pkg::OE_X2;
      flash_pins_pkg::LANE_X4: lane_oe = flash_pins_pkg::OE_X4;
      default:                 lane_oe = flash_pins_pkg::OE_X1;
    endcase
  endfunction : lane_oe

  // Lane values from the top of a byte, high bit on highest lane
  function automatic logic [3:0] lane_val(flash_pins_pkg::lane_mode_t m,
                                          logic [7:0] b);
    case (m)
      flash_pins_pkg::LANE_X2: lane_val = {2'h0, b[7:6]};
      flash_pins_pkg::LANE_X4: lane_val = b[7:4];
      default:                 lane_val = {2'h0, b[7], 1'h0};
    endcase
  endfunction : lane_val

  // Pin synchroniser, select idles high
  pin_sync #(
    .WIDTH (flash_pins_pkg::SYNC_W),
    .INIT  (3'h1)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({si_in, sck, cs_n}),
    .sync_out (pins_s)
  );

  assign cs_s  = pins_s[flash_pins_pkg::SYNC_CS];
  assign sck_s = pins_s[flash_pins_pkg::SYNC_SCK];
  assign si_s  = pins_s[flash_pins_pkg::SYNC_SI];

  // Transmit buffer, drained by falling edges
  byte_fifo #(
    .WIDTH (flash_pins_pkg::BYTE_W),
    .DEPTH (flash_pins_pkg::FIFO_DEPTH)
  ) u_txbuf (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (buf_valid),
    .out_ready (need_byte),
    .out_data  (buf_data)
  );

  // Edge detection on synchronised levels
  assign rise_e   = sck_s && !sck_prev_q;
  assign fall_e   = !sck_s && sck_prev_q;
  assign sel_fall = !cs_s && cs_prev_q;
  assign sel_rise = cs_s && !cs_prev_q;

  // Output lane decode
  assign mode      = flash_pins_pkg::lane_mode_t'(lane_sel);
  assign step      = lane_bits(mode);
  assign tx_fall   = fall_e && !cs_s && out_en;
  assign need_byte = tx_fall && (tx_cnt_q == flash_pins_pkg::CNT_ZERO);
  assign send_byte = !need_byte ? tx_sh_q :
                     buf_valid ? buf_data : flash_pins_pkg::IDLE_FILL;
  assign out_d     = lane_val(mode, send_byte);
  assign oe_d      = (!cs_s && out_en) ? lane_oe(mode)
                                       : flash_pins_pkg::OE_NONE;

  // Previous levels for edge finding
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      cs_prev_q  <= cs_s;
      sck_prev_q <= sck_s;
    end
  end

  // Next link state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      // Wait for select
      flash_pins_pkg::ST_STANDBY:
        if (!cs_s)
          state_d = flash_pins_pkg::ST_SELECTED;
      // Deselect, finish a self-timed cycle first
      flash_pins_pkg::ST_SELECTED:
        if (cs_s)
          state_d = busy_in ? flash_pins_pkg::ST_BUSY
                            : flash_pins_pkg::ST_STANDBY;
      // Internal cycle still running
      flash_pins_pkg::ST_BUSY:
        if (!cs_s)
          state_d = flash_pins_pkg::ST_SELECTED;
        else if (!busy_in)
          state_d = flash_pins_pkg::ST_STANDBY;
      default:
        state_d = flash_pins_pkg::ST_STANDBY;
    endcase
  end

  // Link state and status flags
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q       <= flash_pins_pkg::ST_STANDBY;
      selected_q    <= 1'b0;
      standby_q     <= 1'b1;
      frame_start_q <= 1'b0;
      frame_end_q   <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      selected_q    <= !cs_s;
      standby_q     <= (state_d == flash_pins_pkg::ST_STANDBY);
      frame_start_q <= sel_fall;
      frame_end_q   <= sel_rise;
    end
  end

  // Receive shift on rising edges while selected
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || sel_fall)
    begin
      rx_sh_q  <= 8'h00;
      rx_cnt_q <= flash_pins_pkg::CNT_ZERO;
    end
    else if (rise_e && !cs_s)
    begin
      rx_sh_q  <= {rx_sh_q[6:0], si_s};
      rx_cnt_q <= (rx_cnt_q == flash_pins_pkg::CNT_LAST)
                  ? flash_pins_pkg::CNT_ZERO : rx_cnt_q + 4'h1;
    end
  end

  // Byte out with one-cycle strobe
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= rise_e && !cs_s && (rx_cnt_q == flash_pins_pkg::CNT_LAST);
      if (rise_e && !cs_s && (rx_cnt_q == flash_pins_pkg::CNT_LAST))
        rx_byte_q <= {rx_sh_q[6:0], si_s};
    end
  end

  // Transmit shift on falling edges
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || sel_fall)
    begin
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= flash_pins_pkg::CNT_ZERO;
    end
    else if (tx_fall)
    begin
      tx_sh_q  <= send_byte << step;
      tx_cnt_q <= (need_byte ? flash_pins_pkg::CNT_BYTE : tx_cnt_q) - step;
    end
  end

  // Pin drivers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      io_out_q <= 4'h0;
      io_oe_q  <= flash_pins_pkg::OE_NONE;
    end
    else
    begin
      io_oe_q <= oe_d;
      if (tx_fall)
        io_out_q <= out_d;
    end
  end

  // Independent one-time page locks
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      page_locked_q <= flash_pins_pkg::LOCK_RESET;
    else
      page_locked_q <= page_locked_q | lock_req;
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_DESELECT_STANDBY: assert property (
    (state_q == flash_pins_pkg::ST_SELECTED && cs_s && !busy_in) |=> standby_q)
    else $error("No standby after deselect");

  AST_FRAME_BOUNDS: assert property (
    $fell(cs_s) |=> frame_start_q && !frame_end_q ##1 !frame_start_q)
    else $error("Frame start strobe wrong");

  AST_BUSY_HOLDS: assert property (
    (cs_s && busy_in && state_q != flash_pins_pkg::ST_STANDBY) |=> !standby_q)
    else $error("Standby entered during busy cycle");

  AST_RX_CAPTURE: assert property (
    (rise_e && !cs_s && rx_cnt_q == flash_pins_pkg::CNT_LAST)
      |=> rx_valid_q && (rx_byte_q[0] == $past(si_s)))
    else $error("Received bit not captured on rise");

  AST_OUT_ON_FALL: assert property (
    !$stable(io_out_q) |-> $past(fall_e))
    else $error("Output lane changed off a falling edge");

  AST_QUAD_LANES: assert property (
    (!cs_s && out_en && mode == flash_pins_pkg::LANE_X4) |=> io_oe_q == 4'hf)
    else $error("Quad read does not drive four lanes");

  AST_SINGLE_INPUT: assert property (
    (mode == flash_pins_pkg::LANE_X1) |=> !io_oe_q[0])
    else $error("Input lane driven in single mode");

  AST_LOCK_STICKY: assert property (
    (lock_req == 3'h1) |=> page_locked_q[0] && (page_locked_q[2:1] ==
      $past(page_locked_q[2:1])) ##1 page_locked_q[0])
    else $error("Page lock not independent or sticky");

  AST_IGNORE_DESELECTED: assert property (
    cs_s |=> !rx_valid_q)
    else $error("Input taken while deselected");

  AST_RELEASE_LANES: assert property (
    cs_s[*2] |-> io_oe_q == 4'h0)
    else $error("Lanes driven while deselected");

  AST_START_CLEAN: assert property (
    $fell(cs_s) |=> rx_cnt_q == 4'h0 && tx_cnt_q == 4'h0)
    else $error("Bit counters not cleared at frame start");

  COV_MODE0_FRAME: cover property ($fell(cs_s) && !sck_s);
  COV_MODE3_FRAME: cover property ($fell(cs_s) && sck_s);
  COV_QUAD_READ:   cover property (tx_fall && mode == flash_pins_pkg::LANE_X4);
  COV_BUSY_WAIT:   cover property (state_q == flash_pins_pkg::ST_BUSY);

endmodule : flash_pin_frontend

/* spi_host_model.sv */
`timescale 1ns/1ps

// Host controller driving select, clock and input lane
module spi_host_model (
  // Alignment clock
  input  wire logic       clk_sys,
  // Lanes as seen on the wire
  input  wire logic [3:0] lanes,
  // Pins driven by the host
  output logic            cs_n,
  output logic            sck,
  output logic            si
);
  realtime half = 24.0;  // Half of a 48 ns link period
  logic    cpol = 1'b0;  // Idle clock level

  // Pins idle at time zero
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Step off the system clock edge
  task align();
    @(posedge clk_sys);
    #1.2;
  endtask : align

  // Open a frame with the chosen idle level
  task frame_begin(input logic pol);
    align();
    cpol = pol;
    sck  = pol;
    #half;
    cs_n = 1'b0;
    #half;
  endtask : frame_begin

  // Send one byte, MSB first, set up before the rise
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si  = b[i];
      #half;
      sck = 1'b1;
      #half;
    end
  endtask : send_byte

  // Read one byte over w lanes, sampled on rises
  task read_byte(input int w, output logic [7:0] b);
    if (!sck)
    begin
      sck = 1'b1;
      #half;
    end
    for (int i = 0; i < 8 / w; i++)
    begin
      sck = 1'b0;
      #half;
      sck = 1'b1;
      b = (w == 1) ? {b[6:0], lanes[1]} : (w == 2) ? {b[5:0], lanes[1:0]} : {b[3:0], lanes};
      #half;
    end
  endtask : read_byte

  // Return clock to idle, then deselect
  task frame_end();
    sck = cpol;
    #half;
    cs_n = 1'b1;
    si   = ~si;
  endtask : frame_end

  // Clock and toggle input while deselected
  task noise(input int n);
    align();
    repeat (2 * n)
    begin
      sck = ~sck;
      si  = ~si;
      #half;
    end
  endtask : noise

endmodule : spi_host_model

/* testbench.sv */
`timescale 1ns/1ps

// Self-checking bench for the pin front end
module testbench;
  // Clock, reset and design inputs
  logic       clk_sys  = 1'b0;
  logic       reset_n  = 1'b0;
  logic       tx_valid = 1'b0;
  logic [7:0] tx_data  = 8'h00;
  logic       out_en   = 1'b0;
  logic [1:0] lane_sel = 2'h0;
  logic       busy_in  = 1'b0;
  logic [2:0] lock_req = 3'h0;
  logic       flip     = 1'b0;  // Pattern on released lanes
  // Pins and design outputs
  logic       cs_n, sck, host_si, tx_ready, rx_valid_q;
  logic       selected_q, standby_q, frame_start_q, frame_end_q;
  logic [3:0] io_out_q, io_oe_q, lanes;
  logic [7:0] rx_byte_q;
  logic [2:0] page_locked_q;
  wire        si_in = io_oe_q[0] ? io_out_q[0] : host_si;
  // Bookkeeping
  int         n_errors = 0;
  int         n_checks = 0;
  int         n_start  = 0;
  int         n_end    = 0;
  int         n_frames = 0;
  logic [7:0] rx_q[$];

  // Released lanes show a changing pattern
  assign lanes = (io_oe_q & io_out_q) | (~io_oe_q & {4{flip}});

  always #2.5 clk_sys = ~clk_sys;

  // Collect received bytes and frame strobes
  always @(posedge clk_sys)
  begin
    flip <= ~flip;
    if (rx_valid_q === 1'b1)
      rx_q.push_back(rx_byte_q);
    if (frame_start_q === 1'b1)
      n_start++;
    if (frame_end_q === 1'b1)
      n_end++;
  end

  flash_pin_frontend i_flash_pin_frontend (
    .clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si_in(si_in),
    .io_out_q(io_out_q), .io_oe_q(io_oe_q), .rx_byte_q(rx_byte_q),
    .rx_valid_q(rx_valid_q), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .out_en(out_en), .lane_sel(lane_sel), .busy_in(busy_in),
    .lock_req(lock_req), .page_locked_q(page_locked_q), .selected_q(selected_q),
    .standby_q(standby_q), .frame_start_q(frame_start_q), .frame_end_q(frame_end_q)
  );

  spi_host_model i_spi_host_model (
    .clk_sys(clk_sys), .lanes(lanes), .cs_n(cs_n), .sck(sck), .si(host_si)
  );

  // Expected enables for a lane mode
  function automatic logic [3:0] oe_for(input logic [1:0] s);
    return (s == 2'h1) ? flash_pins_pkg::OE_X2 :
           (s == 2'h2) ? flash_pins_pkg::OE_X4 : flash_pins_pkg::OE_X1;
  endfunction : oe_for

  // Compare a single bit
  task check_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : check_bit

  // Compare a byte
  task check_vec(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check_vec

  // Counts and verdict
  task report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Deselected state after a frame
  task check_idle(input logic sb);
    repeat (8) @(posedge clk_sys);
    check_vec({4'h0, io_oe_q}, {4'h0, flash_pins_pkg::OE_NONE}, "oe idle");
    check_bit(standby_q, sb, "standby");
  endtask : check_idle

  // Write frame of n random bytes
  task automatic rx_frame(input logic pol, input int n);
    logic [7:0] e[$];
    logic [7:0] b;
    rx_q.delete();
    n_frames++;
    i_spi_host_model.frame_begin(pol);
    check_bit(selected_q, 1'b1, "selected");
    check_bit(standby_q, 1'b0, "awake");
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      e.push_back(b);
      i_spi_host_model.send_byte(b);
    end
    i_spi_host_model.frame_end();
    check_idle(1'b1);
    check_vec(8'(rx_q.size()), 8'(n), "rx count");
    foreach (e[i])
      check_vec(rx_q[i], e[i], "rx byte");
    $display("write frame of %0d bytes done", n);
  endtask : rx_frame

  // Read frame: fill until refused, drain past empty
  task automatic rd_frame(input logic [1:0] sel);
    logic [7:0] e[$];
    logic [7:0] b;
    n_frames++;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++)
    begin
      b = 8'($urandom);
      tx_data  <= b;
      tx_valid <= 1'b1;
      if (i < 4)
        e.push_back(b);
      @(posedge clk_sys);
    end
    tx_valid <= 1'b0;
    #1;
    check_bit(tx_ready, 1'b0, "full");
    e.push_back(flash_pins_pkg::IDLE_FILL);
    @(posedge clk_sys);
    out_en   <= 1'b1;
    lane_sel <= sel;
    i_spi_host_model.frame_begin(1'($urandom));
    check_vec({4'h0, io_oe_q}, {4'h0, oe_for(sel)}, "oe read");
    foreach (e[i])
    begin
      i_spi_host_model.read_byte((sel == 2'h1) ? 2 : (sel == 2'h2) ? 4 : 1, b);
      check_vec(b, e[i], "read byte");
    end
    @(posedge clk_sys);
    out_en <= 1'b0;
    i_spi_host_model.frame_end();
    check_idle(1'b1);
    $display("read frame mode %0d done", sel);
  endtask : rd_frame

  // Watchdog
  initial
  begin
    #200_000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    int         p;
    logic [2:0] m;
    void'($urandom(32'h819e));
    repeat (10) @(posedge clk_sys);
    check_bit(standby_q, 1'b1, "reset standby");
    check_vec({4'h0, io_oe_q}, 8'h00, "reset oe");
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rx_frame(1'b0, 3);
    rx_frame(1'b1, 2);
    // Clocks while deselected must not land
    rx_q.delete();
    i_spi_host_model.noise(12);
    repeat (8) @(posedge clk_sys);
    check_vec(8'(rx_q.size()), 8'h00, "deselected rx");
    check_bit(selected_q, 1'b0, "deselected");
    $display("deselected noise done");
    rx_frame(1'b0, 2);
    for (int s = 0; s < 4; s++)
      rd_frame(2'(s));
    // Self-timed cycle holds off standby
    busy_in <= 1'b1;
    n_frames++;
    i_spi_host_model.frame_begin(1'b0);
    i_spi_host_model.frame_end();
    check_idle(1'b0);
    busy_in <= 1'b0;
    @(posedge clk_sys);
    #1;
    check_bit(standby_q, 1'b1, "standby after busy");
    $display("busy test done");
    // Page locks, in turn from a random first page
    m = flash_pins_pkg::LOCK_RESET;
    p = $urandom % 3;
    @(posedge clk_sys);
    repeat (3)
    begin
      lock_req <= 3'(1 << p);
      m = m | 3'(1 << p);
      @(posedge clk_sys);
      lock_req <= 3'h0;
      #1;
      check_vec({5'h0, page_locked_q}, {5'h0, m}, "locks");
      p = (p + 1) % 3;
      @(posedge clk_sys);
    end
    $display("lock test done");
    check_vec(8'(n_start), 8'(n_frames), "starts");
    check_vec(8'(n_end), 8'(n_frames), "ends");
    report_and_stop();
  end

endmodule : testbench
